// File: hw/cfg_option_pkg.sv
package cfg_option_pkg;
    localparam int CFG_WIDTH = 14;
    localparam int DATA_PROT_BIT = 8;
    localparam int PROG_PROT_BIT = 7;
    localparam int RESET_FUNC_BIT = 6;
    localparam int POWERUP_TIMER_BIT = 5;
    localparam int WDT_FIELD_HI = 4;
    localparam int WDT_FIELD_LO = 3;

    localparam logic [1:0] WDT_ALWAYS = 2'h3;
    localparam logic [1:0] WDT_RUN_ONLY = 2'h2;
    localparam logic [1:0] WDT_SOFTWARE = 2'h1;
    localparam logic [1:0] WDT_OFF = 2'h0;

    localparam logic [3:0] CFG_WORD_OFS = 4'h0;
    localparam logic [3:0] WDT_CTRL_OFS = 4'h4;
    localparam logic [3:0] PIN_CTRL_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hC;

    localparam logic [13:0] CFG_RESET_VAL = 14'h3FFF;
    localparam logic WDT_CTRL_RESET_VAL = 1'b0;
    localparam logic PIN_CTRL_RESET_VAL = 1'b0;

    localparam int ST_DATA_PROT = 0;
    localparam int ST_PROG_PROT = 1;
    localparam int ST_EXT_RESET_EN = 2;
    localparam int ST_PULLUP = 3;
    localparam int ST_POWERUP_TIMER = 4;
    localparam int ST_WDT = 5;
    localparam int ST_LOADED = 6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cfg_option_pkg

// File: hw/config_word_option_decode.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] data protect option bit 8: 1 leaves data readable, 0 protects data memory
// [R2] program protect option bit 7: 1 no protection, 0 protects program memory
// [R3] low-voltage programming option 1 makes reset function select bit 6 ignored
// [R4] lvp 0 and select 1: pin is external reset, weak pull-up forced on
// [R5] lvp 0 and select 0: digital input, no reset, pull-up from pin control
// [R6] power-up timer option bit 5 active low: 1 disables, 0 enables
// [R7] watchdog field 11 always on; 10 on while running, off in sleep
// [R8] watchdog field 01 follows the software watchdog enable bit
// [R9] watchdog field 00 keeps watchdog off regardless of software bit
module config_word_option_decode import cfg_option_pkg::*; (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [13:0] config_word_i,
    input wire logic low_voltage_prog_opt_i,
    input wire logic sleep_i,
    input wire logic reset_pin_level_i,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic data_mem_protect_o,
    output logic prog_mem_protect_o,
    output logic external_reset_en_o,
    output logic external_reset_o,
    output logic pin_pullup_en_o,
    output logic pin_digital_o,
    output logic powerup_timer_en_o,
    output logic watchdog_en_o
);

    function automatic logic reg_hit(input logic [31:0] addr, input logic [3:0] ofs);
        reg_hit = (addr[31:4] == 28'h0) && (addr[3:0] == ofs);
    endfunction : reg_hit

    logic [13:0] cfg_r;
    logic cfg_loaded_r;
    logic lvp_r;
    logic sw_watchdog_enable_r;
    logic pin3_pullup_ctrl_r;
    logic [31:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_held_r;

    logic data_mem_protect_n;
    logic prog_mem_protect_n;
    logic reset_pin_func_sel;
    logic powerup_timer_en_n;
    logic [1:0] watchdog_en_field;
    logic reset_pin_is_reset;
    logic pullup_nxt;
    logic watchdog_nxt;

    assign data_mem_protect_n = cfg_r[DATA_PROT_BIT];
    assign prog_mem_protect_n = cfg_r[PROG_PROT_BIT];
    assign reset_pin_func_sel = cfg_r[RESET_FUNC_BIT];
    assign powerup_timer_en_n = cfg_r[POWERUP_TIMER_BIT];
    assign watchdog_en_field = cfg_r[WDT_FIELD_HI:WDT_FIELD_LO];

    // the non-volatile word is sampled once after reset release; later
    // changes on config_word_i have no effect until the next reset
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cfg_r <= CFG_RESET_VAL;
            lvp_r <= 1'b0;
            cfg_loaded_r <= 1'b0;
        end else if (!cfg_loaded_r) begin
            cfg_r <= config_word_i;
            lvp_r <= low_voltage_prog_opt_i;
            cfg_loaded_r <= 1'b1;
        end
    end

    // with lvp set the select bit is ignored and the pin stays a reset pin
    always_comb begin
        if (lvp_r) begin
            reset_pin_is_reset = 1'b1; // [R3]
            pullup_nxt = 1'b1;
        end else if (reset_pin_func_sel) begin
            reset_pin_is_reset = 1'b1; // [R4]
            pullup_nxt = 1'b1; // [R4]
        end else begin
            reset_pin_is_reset = 1'b0; // [R5]
            pullup_nxt = pin3_pullup_ctrl_r; // [R5]
        end
    end

    always_comb begin
        case (watchdog_en_field)
            WDT_ALWAYS: watchdog_nxt = 1'b1; // [R7]
            WDT_RUN_ONLY: watchdog_nxt = !sleep_i; // [R7]
            WDT_SOFTWARE: watchdog_nxt = sw_watchdog_enable_r; // [R8]
            default: watchdog_nxt = 1'b0; // [R9]
        endcase
    end

    // outputs stay in their safe state until the word has been latched
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !cfg_loaded_r) begin
            data_mem_protect_o <= 1'b1;
            prog_mem_protect_o <= 1'b1;
            external_reset_en_o <= 1'b1;
            external_reset_o <= 1'b0;
            pin_pullup_en_o <= 1'b1;
            pin_digital_o <= 1'b0;
            powerup_timer_en_o <= 1'b0;
            watchdog_en_o <= 1'b0;
        end else begin
            data_mem_protect_o <= !data_mem_protect_n; // [R1]
            prog_mem_protect_o <= !prog_mem_protect_n; // [R2]
            external_reset_en_o <= reset_pin_is_reset;
            external_reset_o <= reset_pin_is_reset && !reset_pin_level_i; // [R4]
            pin_pullup_en_o <= pullup_nxt;
            pin_digital_o <= !reset_pin_is_reset && reset_pin_level_i; // [R5]
            powerup_timer_en_o <= !powerup_timer_en_n; // [R6]
            watchdog_en_o <= watchdog_nxt;
        end
    end

    // write address and data may arrive in either order; each is held
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 32'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register update and response in the cycle after both halves are held
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            sw_watchdog_enable_r <= WDT_CTRL_RESET_VAL;
            pin3_pullup_ctrl_r <= PIN_CTRL_RESET_VAL;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_held_r && w_held_r) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (reg_hit(aw_addr_r, WDT_CTRL_OFS)) begin
                if (w_strb_r[0]) begin
                    sw_watchdog_enable_r <= w_data_r[0]; // [R8]
                end
            end else if (reg_hit(aw_addr_r, PIN_CTRL_OFS)) begin
                if (w_strb_r[0]) begin
                    pin3_pullup_ctrl_r <= w_data_r[0]; // [R5]
                end
            end else if (reg_hit(aw_addr_r, CFG_WORD_OFS) || reg_hit(aw_addr_r, STATUS_OFS)) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
            if (reg_hit(s_axi_araddr, CFG_WORD_OFS)) begin
                s_axi_rdata[CFG_WIDTH-1:0] <= cfg_r;
            end else if (reg_hit(s_axi_araddr, WDT_CTRL_OFS)) begin
                s_axi_rdata[0] <= sw_watchdog_enable_r;
            end else if (reg_hit(s_axi_araddr, PIN_CTRL_OFS)) begin
                s_axi_rdata[0] <= pin3_pullup_ctrl_r;
            end else if (reg_hit(s_axi_araddr, STATUS_OFS)) begin
                s_axi_rdata[ST_DATA_PROT] <= data_mem_protect_o;
                s_axi_rdata[ST_PROG_PROT] <= prog_mem_protect_o;
                s_axi_rdata[ST_EXT_RESET_EN] <= external_reset_en_o;
                s_axi_rdata[ST_PULLUP] <= pin_pullup_en_o;
                s_axi_rdata[ST_POWERUP_TIMER] <= powerup_timer_en_o;
                s_axi_rdata[ST_WDT] <= watchdog_en_o;
                s_axi_rdata[ST_LOADED] <= cfg_loaded_r;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end
    end

endmodule : config_word_option_decode

`default_nettype wire

// File: tb/cwod_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cwod_asserts import cfg_option_pkg::*; (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [13:0] config_word_i,
    input wire logic low_voltage_prog_opt_i,
    input wire logic sleep_i,
    input wire logic reset_pin_level_i,
    input wire logic data_mem_protect_o,
    input wire logic prog_mem_protect_o,
    input wire logic external_reset_en_o,
    input wire logic external_reset_o,
    input wire logic pin_pullup_en_o,
    input wire logic powerup_timer_en_o,
    input wire logic watchdog_en_o
);
    // config is taken only after reset, so skip the load edges
    logic [1:0] age_r;
    logic loaded;
    logic [1:0] fld;
    assign loaded = age_r == 2'h3;
    assign fld = config_word_i[WDT_FIELD_HI:WDT_FIELD_LO];
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_data_prot: assert property (loaded |-> data_mem_protect_o == !config_word_i[8])
        else $error("data protect wrong");
    a_prog_prot: assert property (loaded |-> prog_mem_protect_o == !config_word_i[7])
        else $error("program protect wrong");
    a_reset_select: assert property (loaded |->
        external_reset_en_o == (low_voltage_prog_opt_i || config_word_i[6]))
        else $error("reset function wrong");
    a_pullup_forced: assert property (loaded && external_reset_en_o |-> pin_pullup_en_o)
        else $error("pull-up not forced");
    a_pin_reset: assert property (loaded |=>
        external_reset_o == (external_reset_en_o && !$past(reset_pin_level_i)))
        else $error("external reset wrong");
    a_powerup_timer_low: assert property (loaded |-> powerup_timer_en_o == !config_word_i[5])
        else $error("power-up timer wrong");
    a_wdt_always: assert property (loaded && fld == WDT_ALWAYS |-> watchdog_en_o [*3])
        else $error("watchdog not on");
    a_wdt_sleep: assert property (loaded && fld == WDT_RUN_ONLY |=>
        watchdog_en_o != $past(sleep_i))
        else $error("watchdog sleep wrong");
    a_wdt_off: assert property (loaded && fld == WDT_OFF |-> !watchdog_en_o)
        else $error("watchdog not off");
endmodule : cwod_asserts
`default_nettype wire

// File: tb/config_word_option_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module config_word_option_decode_bench import cfg_option_pkg::*;;
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1;
    logic [13:0] config_word_i = 14'h3FFF;
    logic low_voltage_prog_opt_i = 1'b0, sleep_i = 1'b0, reset_pin_level_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic data_mem_protect_o, prog_mem_protect_o, external_reset_en_o, external_reset_o;
    logic pin_pullup_en_o, pin_digital_o, powerup_timer_en_o, watchdog_en_o;
    logic [7:0] outs;
    int n_fail = 0, cmp_count = 0, tick = 0;
    assign outs = {data_mem_protect_o, prog_mem_protect_o, external_reset_en_o, external_reset_o,
        pin_pullup_en_o, pin_digital_o, powerup_timer_en_o, watchdog_en_o};
    always #10 core_clk_i = ~core_clk_i;
    config_word_option_decode DUT (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .config_word_i(config_word_i),
        .low_voltage_prog_opt_i(low_voltage_prog_opt_i),
        .sleep_i(sleep_i),
        .reset_pin_level_i(reset_pin_level_i),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .data_mem_protect_o(data_mem_protect_o),
        .prog_mem_protect_o(prog_mem_protect_o),
        .external_reset_en_o(external_reset_en_o),
        .external_reset_o(external_reset_o),
        .pin_pullup_en_o(pin_pullup_en_o),
        .pin_digital_o(pin_digital_o),
        .powerup_timer_en_o(powerup_timer_en_o),
        .watchdog_en_o(watchdog_en_o)
    );
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    always @(posedge core_clk_i) begin
        tick++;
        if (tick == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    // config word is only re-sampled after a reset, so each case boots anew
    task automatic boot(input logic [13:0] c, input logic l);
        config_word_i <= c;
        low_voltage_prog_opt_i <= l;
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask : boot
    task automatic settle();
        repeat (3) @(posedge core_clk_i);
    endtask : settle
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk_i);
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk_i);
    endtask : axi_rd
    initial begin
        boot(14'h3FFF, 1'b0);
        `CHK(outs, 8'h39)
        axi_rd({28'h0, CFG_WORD_OFS});
        `CHK(rd, 32'h00003FFF)
        axi_rd({28'h0, STATUS_OFS});
        `CHK(rd, 32'h0000006C)
        axi_rd(32'h00000010);
        `CHK(resp, RESP_SLVERR)
        `CHK(rd, 32'h0)
        $display("test 1 done");
        reset_pin_level_i <= 1'b1;
        boot(14'h0010, 1'b0);
        `CHK(outs, 8'hC7)
        sleep_i <= 1'b1;
        reset_pin_level_i <= 1'b0;
        axi_wr({28'h0, PIN_CTRL_OFS}, 32'h1);
        `CHK(resp, RESP_OKAY)
        settle();
        `CHK(outs, 8'hCA)
        $display("test 2 done");
        reset_pin_level_i <= 1'b1;
        boot(14'h0008, 1'b1);
        `CHK(outs, 8'hEA)
        axi_wr({28'h0, WDT_CTRL_OFS}, 32'h1);
        settle();
        `CHK(outs, 8'hEB)
        axi_wr({28'h0, CFG_WORD_OFS}, 32'h0);
        axi_rd({28'h0, CFG_WORD_OFS});
        `CHK(rd, 32'h00000008)
        $display("test 3 done");
        boot(14'h0000, 1'b0);
        axi_wr({28'h0, WDT_CTRL_OFS}, 32'h1);
        settle();
        `CHK(outs, 8'hC6)
        $display("test 4 done");
        give_verdict();
    end
endmodule : config_word_option_decode_bench
bind config_word_option_decode cwod_asserts CHKR (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .config_word_i(config_word_i),
    .low_voltage_prog_opt_i(low_voltage_prog_opt_i),
    .sleep_i(sleep_i),
    .reset_pin_level_i(reset_pin_level_i),
    .data_mem_protect_o(data_mem_protect_o),
    .prog_mem_protect_o(prog_mem_protect_o),
    .external_reset_en_o(external_reset_en_o),
    .external_reset_o(external_reset_o),
    .pin_pullup_en_o(pin_pullup_en_o),
    .powerup_timer_en_o(powerup_timer_en_o),
    .watchdog_en_o(watchdog_en_o)
);
`default_nettype wire
